/* include/conv_seq_pkg.sv */
// Package for the converter slot sequencing block.
// Assumes a classic Wishbone slave with 32-bit data and one 40 MHz clock.
package conv_seq_pkg;
	// Register byte addresses (index times four)
	localparam logic [7:0] IDX_CONV2_SLOTS  = 8'hB8;
	localparam logic [7:0] IDX_CONV3_CTRL   = 8'hBA;
	localparam logic [7:0] IDX_CONV3_SLOTS  = 8'hBB;
	localparam logic [9:0] ADR_CONV2_SLOTS  = 10'h02E0;
	localparam logic [9:0] ADR_CONV3_CTRL   = 10'h02E8;
	localparam logic [9:0] ADR_CONV3_SLOTS  = 10'h02EC;
	localparam logic [9:0] ADR_SEQ_CMD      = 10'h0300;
	localparam logic [9:0] ADR_SEQ_STATUS   = 10'h0304;
	localparam logic [9:0] ADR_IRQ_STATUS   = 10'h0308;
	localparam logic [9:0] ADR_IRQ_MASK     = 10'h030C;
	// Field positions
	localparam int FLD_ACT_LO   = 14;
	localparam int FLD_UP_LO    = 10;
	localparam int FLD_DN_LO    = 6;
	localparam int FLD_OVP_BIT  = 11;
	localparam int FLD_FLT_BIT  = 10;
	// Fault action codes
	localparam logic [1:0] ACT_IGNORE   = 2'h0;
	localparam logic [1:0] ACT_CONV_OFF = 2'h1;
	// Slot codes
	localparam logic [3:0] SLOT_NONE    = 4'h0;
	localparam logic [3:0] SLOT_ACTIVE  = 4'hF;
	localparam logic [3:0] SLOT_LAST    = 4'hE;
	// Defaults restored by reset and by the power state machine
	localparam logic [15:0] DEF_CONV2_SLOTS = 16'h0000;
	localparam logic [15:0] DEF_CONV3_SLOTS = 16'h0000;
	localparam logic [15:0] DEF_CONV3_CTRL  = 16'h0000;
	// Slot timing
	localparam int SLOT_TIME_US = 2;
	localparam int CLK_MHZ      = 40;
	localparam int SLOT_CYCLES  = SLOT_TIME_US * CLK_MHZ;
	// Power states
	typedef enum logic [2:0] {PS_OFF, PS_UP, PS_ACTIVE, PS_DOWN} pstate_t;
	// Per-converter setting fields
	typedef struct packed {
		logic [1:0] action;
		logic [3:0] up_slot;
		logic [3:0] dn_slot;
	} conv_cfg_t;
endpackage

/* rtl/conv_seq.sv */
// Slot sequencer and fault handling for the second and third converters.
// Assumes a classic Wishbone master; fault inputs are asynchronous pins.
// Functional notes
// - Fault action 00 ignores a fault, 01 stops that converter, 10 stops the system.
// - Fault action 11 acts the same as the system shutdown code.
// - Every converter fault raises an interrupt whatever the action.
// - Start-up slot codes 1 to 14 enable the converter in that sequencer slot.
// - Start-up slot code 0 keeps the converter off during power-up.
// - Start-up slot code 15 enables the converter on entering ACTIVE.
// - Shutdown slot codes 1 to 14 disable the converter in that slot.
// - Shutdown slot codes 0 and 15 disable the converter on entering OFF.
// - Control bit 11 set turns off the third converter's over-voltage protection.
// - With control bit 10 clear, the disabled third converter is discharged.
// - With control bit 10 set, the disabled third converter output floats.
// - Bits 6:0 set the third converter voltage code, 25 mV steps from 0.85 V.
// - The power state machine restores all fields to defaults on reaching OFF.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module conv_seq #(
	parameter int SLOT_CYC = conv_seq_pkg::SLOT_CYCLES
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [9:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// Converter faults (asynchronous)
	input  wire logic [1:0]  FAULT_IN,
	// Converter controls
	output logic      [1:0]  CONV_ENABLE,
	output logic             CONV3_OVP_OFF,
	output logic             CONV3_DISCHARGE,
	output logic      [6:0]  CONV3_VOLTAGE_CODE,
	output logic             SYS_SHUTDOWN,
	output logic             IRQ
);
	// Refuse slot lengths that the 16-bit tick counter cannot hold
	if (SLOT_CYC < 1 || SLOT_CYC > 65535) begin : g_bad_slot
		$error("SLOT_CYC out of range");
	end

	// Registers
	logic [15:0] slots_ff [2];
	logic [15:0] ctrl_ff;
	logic [1:0]  irq_st_ff;
	logic [1:0]  irq_mask_ff;
	logic [1:0]  en_ff;
	logic [1:0]  flt_s1_ff;
	logic [1:0]  flt_s2_ff;
	logic [1:0]  flt_d_ff;
	logic [15:0] tick_ff;
	logic [3:0]  slot_ff;
	logic        sys_off_ff;
	logic        ovp_ff;
	logic        dis_ff;
	logic [6:0]  vcode_ff;
	logic        irq_ff;
	logic [31:0] rdat_ff;
	logic        ack_ff;
	conv_seq_pkg::pstate_t st_ff;
	conv_seq_pkg::pstate_t nxt_st;

	// Bus decode
	wire         bus_req  = WB_CYC_I && WB_STB_I && !ack_ff;
	wire         bus_wr   = bus_req && WB_WE_I;
	wire         lo_lanes = WB_SEL_I[0] && WB_SEL_I[1];
	wire         wr_s2    = bus_wr && lo_lanes && WB_ADR_I == conv_seq_pkg::ADR_CONV2_SLOTS;
	wire         wr_s3    = bus_wr && lo_lanes && WB_ADR_I == conv_seq_pkg::ADR_CONV3_SLOTS;
	wire         wr_ctl   = bus_wr && lo_lanes && WB_ADR_I == conv_seq_pkg::ADR_CONV3_CTRL;
	wire         wr_cmd   = bus_wr && WB_SEL_I[0] && WB_ADR_I == conv_seq_pkg::ADR_SEQ_CMD;
	wire         wr_ist   = bus_wr && WB_SEL_I[0] && WB_ADR_I == conv_seq_pkg::ADR_IRQ_STATUS;
	wire         wr_imk   = bus_wr && WB_SEL_I[0] && WB_ADR_I == conv_seq_pkg::ADR_IRQ_MASK;
	wire         cmd_up   = wr_cmd && WB_DAT_I[0];
	wire         cmd_down = wr_cmd && WB_DAT_I[1];

	// Sequencer timing
	wire         tick_end = tick_ff == 16'(SLOT_CYC - 1);
	wire         step_end = tick_end && slot_ff == conv_seq_pkg::SLOT_LAST;
	wire         enter_off = st_ff != conv_seq_pkg::PS_OFF && nxt_st == conv_seq_pkg::PS_OFF;
	wire         enter_act = st_ff == conv_seq_pkg::PS_UP && nxt_st == conv_seq_pkg::PS_ACTIVE;

	// Fault edges and actions
	wire [1:0]   flt_rise = flt_s2_ff & ~flt_d_ff;
	logic [1:0]  conv_kill;
	logic [1:0]  sys_kill;
	conv_seq_pkg::conv_cfg_t cfg [2];
	logic [1:0]  nxt_en;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_conv
			assign cfg[g] = conv_seq_pkg::conv_cfg_t'(slots_ff[g][15:6]);
			// Fault action decode; codes 10 and 11 both stop the system
			assign conv_kill[g] = flt_rise[g] &&
				cfg[g].action == conv_seq_pkg::ACT_CONV_OFF;
			assign sys_kill[g] = flt_rise[g] && cfg[g].action[1];
			// Enable next value from slots, state entries and faults
			always_comb begin
				nxt_en[g] = en_ff[g];
				if (st_ff == conv_seq_pkg::PS_UP && tick_end && cfg[g].up_slot == slot_ff &&
					cfg[g].up_slot != conv_seq_pkg::SLOT_NONE)
					nxt_en[g] = 1'b1;
				if (enter_act && cfg[g].up_slot == conv_seq_pkg::SLOT_ACTIVE)
					nxt_en[g] = 1'b1;
				if (st_ff == conv_seq_pkg::PS_DOWN && tick_end && cfg[g].dn_slot == slot_ff)
					nxt_en[g] = 1'b0;
				if (enter_off)
					nxt_en[g] = 1'b0;
				if (conv_kill[g])
					nxt_en[g] = 1'b0;
			end
		end
	endgenerate

	wire any_sys_kill = |sys_kill;

	// Power state machine
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			conv_seq_pkg::PS_OFF: begin
				if (cmd_up && !any_sys_kill) // A fault stop outranks a start request
					nxt_st = conv_seq_pkg::PS_UP;
			end
			conv_seq_pkg::PS_UP: begin
				if (any_sys_kill)
					nxt_st = conv_seq_pkg::PS_OFF;
				else if (step_end)
					nxt_st = conv_seq_pkg::PS_ACTIVE;
			end
			conv_seq_pkg::PS_ACTIVE: begin
				if (any_sys_kill)
					nxt_st = conv_seq_pkg::PS_OFF;
				else if (cmd_down)
					nxt_st = conv_seq_pkg::PS_DOWN;
			end
			conv_seq_pkg::PS_DOWN: begin
				if (any_sys_kill || step_end)
					nxt_st = conv_seq_pkg::PS_OFF;
			end
			default: nxt_st = conv_seq_pkg::PS_OFF;
		endcase
	end

	// Slot counter advances one slot per slot period
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_ff   <= conv_seq_pkg::PS_OFF;
			tick_ff <= 16'h0000;
			slot_ff <= 4'h1;
		end else begin
			st_ff <= nxt_st;
			if (nxt_st != st_ff) begin
				tick_ff <= 16'h0000;
				slot_ff <= 4'h1;
			end else if (tick_end) begin
				tick_ff <= 16'h0000;
				slot_ff <= slot_ff + 4'h1;
			end else begin
				tick_ff <= tick_ff + 16'h0001;
			end
		end
	end

	// Fault synchronisers
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			flt_s1_ff <= 2'h0;
			flt_s2_ff <= 2'h0;
			flt_d_ff  <= 2'h0;
		end else begin
			flt_s1_ff <= FAULT_IN;
			flt_s2_ff <= flt_s1_ff;
			flt_d_ff  <= flt_s2_ff;
		end
	end

	// Setting registers, restored to defaults on entering OFF
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			slots_ff[0] <= conv_seq_pkg::DEF_CONV2_SLOTS;
			slots_ff[1] <= conv_seq_pkg::DEF_CONV3_SLOTS;
			ctrl_ff     <= conv_seq_pkg::DEF_CONV3_CTRL;
		end else if (enter_off) begin
			slots_ff[0] <= conv_seq_pkg::DEF_CONV2_SLOTS;
			slots_ff[1] <= conv_seq_pkg::DEF_CONV3_SLOTS;
			ctrl_ff     <= conv_seq_pkg::DEF_CONV3_CTRL;
		end else begin
			if (wr_s2)
				slots_ff[0] <= WB_DAT_I[15:0];
			if (wr_s3)
				slots_ff[1] <= WB_DAT_I[15:0];
			if (wr_ctl)
				ctrl_ff <= WB_DAT_I[15:0] & 16'h0C7F;
		end
	end

	// Interrupt status: a fault sets, write one clears, set wins
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_st_ff   <= 2'h0;
			irq_mask_ff <= 2'h0;
			irq_ff      <= 1'b0;
		end else begin
			irq_st_ff <= (irq_st_ff & ~(wr_ist ? WB_DAT_I[1:0] : 2'h0)) | flt_rise;
			if (wr_imk)
				irq_mask_ff <= WB_DAT_I[1:0];
			irq_ff <= |(irq_st_ff & irq_mask_ff);
		end
	end

	// Converter outputs
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			en_ff      <= 2'h0;
			sys_off_ff <= 1'b0;
			ovp_ff     <= 1'b0;
			dis_ff     <= 1'b1;
			vcode_ff   <= 7'h00;
		end else begin
			en_ff      <= nxt_en;
			sys_off_ff <= any_sys_kill;
			ovp_ff     <= ctrl_ff[conv_seq_pkg::FLD_OVP_BIT];
			dis_ff     <= !nxt_en[1] && !ctrl_ff[conv_seq_pkg::FLD_FLT_BIT];
			vcode_ff   <= ctrl_ff[6:0];
		end
	end

	// Read mux
	logic [31:0] rd_mux;
	always_comb begin
		case (WB_ADR_I)
			conv_seq_pkg::ADR_CONV2_SLOTS: rd_mux = {16'h0000, slots_ff[0]};
			conv_seq_pkg::ADR_CONV3_SLOTS: rd_mux = {16'h0000, slots_ff[1]};
			conv_seq_pkg::ADR_CONV3_CTRL:  rd_mux = {16'h0000, ctrl_ff};
			conv_seq_pkg::ADR_SEQ_STATUS:  rd_mux = {24'h0000_00, 1'b0, st_ff, en_ff, 2'h0};
			conv_seq_pkg::ADR_IRQ_STATUS:  rd_mux = {30'h0000_0000, irq_st_ff};
			conv_seq_pkg::ADR_IRQ_MASK:    rd_mux = {30'h0000_0000, irq_mask_ff};
			default:                       rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus answer: one cycle after the request, for one cycle
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ack_ff  <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else begin
			ack_ff  <= bus_req;
			rdat_ff <= bus_req ? rd_mux : 32'h0000_0000;
		end
	end

	assign WB_ACK_O           = ack_ff;
	assign WB_DAT_O           = rdat_ff;
	assign CONV_ENABLE        = en_ff;
	assign CONV3_OVP_OFF      = ovp_ff;
	assign CONV3_DISCHARGE    = dis_ff;
	assign CONV3_VOLTAGE_CODE = vcode_ff;
	assign SYS_SHUTDOWN       = sys_off_ff;
	assign IRQ                = irq_ff;

	// Checks
	chk_fault_irq: assert property (@(posedge CLK) disable iff (!ARST_N)
		flt_rise[0] |=> irq_st_ff[0]) else $error("fault did not set status");
	chk_ignore_keeps: assert property (@(posedge CLK) disable iff (!ARST_N)
		flt_rise[0] && cfg[0].action == conv_seq_pkg::ACT_IGNORE && !enter_off
		&& st_ff == conv_seq_pkg::PS_ACTIVE |=> en_ff[0] == $past(en_ff[0]))
		else $error("ignored fault changed enable");
	// A converter stop code turns the faulty converter off
	chk_conv_kill: assert property (@(posedge CLK) disable iff (!ARST_N)
		conv_kill != 2'h0 |=> (en_ff & $past(conv_kill)) == 2'h0)
		else $error("converter not stopped");
	chk_reserved_sys: assert property (@(posedge CLK) disable iff (!ARST_N)
		(flt_rise[0] && cfg[0].action == 2'h3) || (flt_rise[1] && cfg[1].action == 2'h3)
		|=> SYS_SHUTDOWN && st_ff == conv_seq_pkg::PS_OFF)
		else $error("reserved code did not stop system");
	chk_off_clears: assert property (@(posedge CLK) disable iff (!ARST_N)
		enter_off |=> en_ff == 2'h0 && slots_ff[0] == conv_seq_pkg::DEF_CONV2_SLOTS)
		else $error("off entry left state");
	chk_none_stays: assert property (@(posedge CLK) disable iff (!ARST_N)
		st_ff == conv_seq_pkg::PS_UP && cfg[0].up_slot == conv_seq_pkg::SLOT_NONE
		&& !en_ff[0] |=> !en_ff[0]) else $error("slot zero started");
	chk_active_up: assert property (@(posedge CLK) disable iff (!ARST_N)
		enter_act && cfg[1].up_slot == conv_seq_pkg::SLOT_ACTIVE |=> en_ff[1])
		else $error("active start missed");
	// Discharge stands exactly while the third converter is off and not floating
	chk_discharge: assert property (@(posedge CLK) disable iff (!ARST_N)
		CONV3_DISCHARGE == (!CONV_ENABLE[1] && !$past(ctrl_ff[conv_seq_pkg::FLD_FLT_BIT])))
		else $error("no discharge");
	chk_ack_one: assert property (@(posedge CLK) disable iff (!ARST_N)
		WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
	// System stop codes raise the pulse and force OFF
	chk_sys_pulse: assert property (@(posedge CLK) disable iff (!ARST_N)
		sys_kill != 2'h0 |=> SYS_SHUTDOWN && st_ff == conv_seq_pkg::PS_OFF)
		else $error("system stop missed");
	// A numbered start-up slot enables the converter at its end
	chk_slot_start: assert property (@(posedge CLK) disable iff (!ARST_N)
		st_ff == conv_seq_pkg::PS_UP && tick_end && cfg[0].up_slot == slot_ff
		&& !conv_kill[0] && !enter_off |=> en_ff[0])
		else $error("start-up slot missed");
	// A numbered shutdown slot disables the converter at its end
	chk_slot_stop: assert property (@(posedge CLK) disable iff (!ARST_N)
		st_ff == conv_seq_pkg::PS_DOWN && tick_end && cfg[0].dn_slot == slot_ff
		|=> !en_ff[0])
		else $error("shutdown slot missed");
	// Slots are visited one by one in rising order
	chk_step_order: assert property (@(posedge CLK) disable iff (!ARST_N)
		st_ff == conv_seq_pkg::PS_UP && tick_end && nxt_st == conv_seq_pkg::PS_UP
		|=> slot_ff == $past(slot_ff) + 4'h1)
		else $error("slot order broken");
	// Protection switch and voltage code follow a control write two cycles on
	chk_ovp_follow: assert property (@(posedge CLK) disable iff (!ARST_N)
		wr_ctl && !enter_off |=> ##1
		CONV3_OVP_OFF == $past(WB_DAT_I[conv_seq_pkg::FLD_OVP_BIT], 2))
		else $error("protection switch wrong");
	chk_vcode_follow: assert property (@(posedge CLK) disable iff (!ARST_N)
		wr_ctl && !enter_off |=> ##1 CONV3_VOLTAGE_CODE == $past(WB_DAT_I[6:0], 2))
		else $error("voltage code wrong");
	// A set float bit never discharges
	chk_float_off: assert property (@(posedge CLK) disable iff (!ARST_N)
		$past(ctrl_ff[conv_seq_pkg::FLD_FLT_BIT]) |-> !CONV3_DISCHARGE)
		else $error("floating output discharged");
	// Every field of the third converter returns to its default on OFF entry
	chk_restore_all: assert property (@(posedge CLK) disable iff (!ARST_N)
		enter_off |=> ctrl_ff == conv_seq_pkg::DEF_CONV3_CTRL
		&& slots_ff[1] == conv_seq_pkg::DEF_CONV3_SLOTS)
		else $error("settings not restored");
	// A cleared mask keeps the interrupt line low
	chk_irq_masked: assert property (@(posedge CLK) disable iff (!ARST_N)
		irq_mask_ff == 2'h0 |=> !IRQ)
		else $error("masked interrupt raised");
	// Main scenarios
	cov_up_done: cover property (@(posedge CLK) enter_act);
	cov_sys_kill: cover property (@(posedge CLK) any_sys_kill);
	cov_slot_up: cover property (@(posedge CLK) en_ff[0] && !$past(en_ff[0]));
	cov_conv_stop: cover property (@(posedge CLK) conv_kill != 2'h0);
	cov_down_done: cover property (@(posedge CLK) st_ff == conv_seq_pkg::PS_DOWN && step_end);
endmodule

/* verification/tb_top.sv */
// Self-checking bench for the converter slot sequencer and its fault handling.
// Assumes the package is compiled first; slots are shortened to four clock cycles.
`timescale 1ns/1ps
module tb_top;
	localparam int SC = 4;
	logic        CLK, ARST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
	logic [9:0]  WB_ADR_I;
	logic [3:0]  WB_SEL_I;
	logic [31:0] WB_DAT_I, WB_DAT_O, q;
	logic [1:0]  FAULT_IN, CONV_ENABLE;
	logic        CONV3_OVP_OFF, CONV3_DISCHARGE, SYS_SHUTDOWN, IRQ;
	logic [6:0]  CONV3_VOLTAGE_CODE;
	int          err_total, n_checks, sd_cnt, t2, t3, s2, s3, sd0;
	logic [31:0] d;

	conv_seq #(.SLOT_CYC(SC)) u_dut (
		.CLK(CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
		.WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
		.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .FAULT_IN(FAULT_IN),
		.CONV_ENABLE(CONV_ENABLE), .CONV3_OVP_OFF(CONV3_OVP_OFF),
		.CONV3_DISCHARGE(CONV3_DISCHARGE), .CONV3_VOLTAGE_CODE(CONV3_VOLTAGE_CODE),
		.SYS_SHUTDOWN(SYS_SHUTDOWN), .IRQ(IRQ));

	// Free-running 40 MHz clock
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end

	// Count system shutdown pulses
	always @(posedge CLK) begin
		if (SYS_SHUTDOWN === 1'b1) sd_cnt++;
	end

	// Expected read-back of the third converter control register
	function automatic logic [31:0] ctrl_exp(input logic [31:0] v);
		return v & 32'h0000_0C7F;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One classic Wishbone cycle; waits for the acknowledge under a bound
	task automatic wb(input logic we_v, input logic [9:0] a, input logic [31:0] dv,
			output logic [31:0] rq);
		int n;
		n = 0;
		WB_CYC_I <= 1'b1;
		WB_STB_I <= 1'b1;
		WB_WE_I  <= we_v;
		WB_ADR_I <= a;
		WB_DAT_I <= dv;
		WB_SEL_I <= 4'hF;
		@(posedge CLK);
		while (WB_ACK_O !== 1'b1 && n < 50) begin
			@(posedge CLK);
			n++;
		end
		if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
		rq = WB_DAT_O;
		WB_CYC_I <= 1'b0;
		WB_STB_I <= 1'b0;
		WB_WE_I  <= 1'b0;
		@(posedge CLK);
	endtask

	// Issue a sequencer command and note the cycle each enable first changes
	task automatic run(input logic [31:0] cmd, output int e2, output int e3);
		logic [1:0]  e0;
		logic [31:0] rq;
		int          i;
		wb(1'b1, conv_seq_pkg::ADR_SEQ_CMD, cmd, rq);
		e0 = CONV_ENABLE;
		e2 = -1;
		e3 = -1;
		for (i = 0; i < 16 * SC + 20; i++) begin
			@(posedge CLK);
			if (e2 < 0 && CONV_ENABLE[0] !== e0[0]) e2 = i;
			if (e3 < 0 && CONV_ENABLE[1] !== e0[1]) e3 = i;
		end
	endtask

	// Watchdog against a hung handshake or sequence
	initial begin
		#(25 * 20000);
		err_total++;
		end_of_test();
	end

	// Main sequence
	initial begin
		{WB_CYC_I, WB_STB_I, WB_WE_I, FAULT_IN} = 5'h00;
		{WB_ADR_I, WB_DAT_I, WB_SEL_I} = '0;
		ARST_N = 1'b0;
		{err_total, n_checks, sd_cnt} = '0;
		void'($urandom(32'hfe83));
		repeat (16) @(posedge CLK);
		ARST_N   <= 1'b1;
		WB_SEL_I <= 4'hF;
		@(posedge CLK);
		chk({30'h0, CONV_ENABLE}, 32'h0000_0000);
		chk({31'h0, CONV3_DISCHARGE}, 32'h0000_0001);
		wb(1'b0, conv_seq_pkg::ADR_CONV3_SLOTS, 32'h0, q);
		chk(q, 32'(conv_seq_pkg::DEF_CONV3_SLOTS));
		// Control fields, voltage code 66 hex with bits 11 and 10 set first, then random codes
		for (int i = 0; i < 6; i++) begin
			d = (i == 0) ? 32'h0000_0C66 : $urandom;
			wb(1'b1, conv_seq_pkg::ADR_CONV3_CTRL, d, q);
			wb(1'b0, conv_seq_pkg::ADR_CONV3_CTRL, 32'h0, q);
			chk(q, ctrl_exp(d));
			chk({31'h0, CONV3_OVP_OFF}, {31'h0, d[11]});
			chk({31'h0, CONV3_DISCHARGE}, {31'h0, ~d[10]});
			chk({25'h0, CONV3_VOLTAGE_CODE}, {25'h0, d[6:0]});
		end
		wb(1'b0, 10'h3F0, 32'h0, q);
		chk(q, 32'h0000_0000);
		wb(1'b1, conv_seq_pkg::ADR_CONV3_CTRL, 32'h0, q);
		// Ascending start-up slots, spacing fixed by the slot length
		s2 = 1 + $urandom % 13;
		s3 = s2 + 1 + $urandom % (14 - s2);
		wb(1'b1, conv_seq_pkg::ADR_CONV2_SLOTS, 32'(s2) << 10, q);
		wb(1'b1, conv_seq_pkg::ADR_CONV3_SLOTS, (32'(s3) << 10) | 32'h0000_03C0, q);
		run(32'h0000_0001, t2, t3);
		chk(32'(t3 - t2), 32'((s3 - s2) * SC));
		chk({31'h0, CONV3_DISCHARGE}, 32'h0000_0000);
		wb(1'b0, conv_seq_pkg::ADR_SEQ_STATUS, 32'h0, q);
		chk({29'h0, q[6:4]}, 32'h0000_0002);
		// Shutdown: numbered slot for conv2, code 15 holds conv3 until OFF
		s2 = 1 + $urandom % 14;
		wb(1'b1, conv_seq_pkg::ADR_CONV2_SLOTS, 32'(s2) << 6, q);
		run(32'h0000_0002, t2, t3);
		chk({31'h0, t2 >= 0}, 32'h0000_0001);
		chk(32'(t3 - t2), 32'((14 - s2) * SC));
		wb(1'b0, conv_seq_pkg::ADR_CONV3_SLOTS, 32'h0, q);
		chk(q, 32'(conv_seq_pkg::DEF_CONV3_SLOTS));
		chk({31'h0, CONV3_DISCHARGE}, 32'h0000_0001);
		// Code 0 never starts, code 15 waits for ACTIVE
		wb(1'b1, conv_seq_pkg::ADR_CONV3_SLOTS, 32'h0000_3C00, q);
		run(32'h0000_0001, t2, t3);
		chk(32'(t2), 32'hFFFF_FFFF);
		chk({31'h0, t3 > 13 * SC}, 32'h0000_0001);
		run(32'h0000_0002, t2, t3);
		// Every fault action code on conv2 while ACTIVE
		for (int act = 0; act < 4; act++) begin
			wb(1'b1, conv_seq_pkg::ADR_CONV2_SLOTS, (32'(act) << 14) | 32'h0000_0400, q);
			run(32'h0000_0001, t2, t3);
			wb(1'b1, conv_seq_pkg::ADR_IRQ_MASK, 32'h0000_0003, q);
			sd0 = sd_cnt;
			FAULT_IN <= 2'b01;
			repeat (8) @(posedge CLK);
			chk({31'h0, IRQ}, 32'h0000_0001);
			chk({31'h0, CONV_ENABLE[0]}, {31'h0, act == 0});
			chk(32'(sd_cnt - sd0), {31'h0, act >= 2});
			wb(1'b0, conv_seq_pkg::ADR_IRQ_STATUS, 32'h0, q);
			chk({30'h0, q[1:0]}, 32'h0000_0001);
			wb(1'b1, conv_seq_pkg::ADR_IRQ_STATUS, 32'h0000_0001, q);
			FAULT_IN <= 2'b00;
			repeat (2) @(posedge CLK);
			chk({31'h0, IRQ}, 32'h0000_0000);
			if (act < 2) run(32'h0000_0002, t2, t3);
			wb(1'b0, conv_seq_pkg::ADR_SEQ_STATUS, 32'h0, q);
			chk({29'h0, q[6:4]}, 32'h0000_0000);
		end
		// Masked conv3 fault, ignored action, still latched
		wb(1'b1, conv_seq_pkg::ADR_IRQ_MASK, 32'h0000_0000, q);
		FAULT_IN <= 2'b10;
		repeat (8) @(posedge CLK);
		chk({31'h0, IRQ}, 32'h0000_0000);
		wb(1'b0, conv_seq_pkg::ADR_IRQ_STATUS, 32'h0, q);
		chk({30'h0, q[1:0]}, 32'h0000_0002);
		wb(1'b1, conv_seq_pkg::ADR_IRQ_MASK, 32'h0000_0002, q);
		repeat (2) @(posedge CLK);
		chk({31'h0, IRQ}, 32'h0000_0001);
		FAULT_IN <= 2'b00;
		end_of_test();
	end
endmodule
